// file: dcts_params.svh
// Constants for the dual channel time stamp counter.
`ifndef DCTS_PARAMS_SVH
`define DCTS_PARAMS_SVH
`define DCTS_CLK_PERIOD_NS 20
`define DCTS_SYS_RES_NS    10
`define DCTS_HOLDOFF_NS    16000
`define DCTS_TICK_NS       10000000
`define DCTS_AVG_MAX       625
`define DCTS_GATE_RST      32'h0000000a
`define DCTS_TOUT_RST      32'h00000064
`define DCTS_A_CTRL        8'h00
`define DCTS_A_GATE        8'h04
`define DCTS_A_TOUT        8'h08
`define DCTS_A_ISTAT       8'h0c
`define DCTS_A_IMASK       8'h10
`define DCTS_A_SYS         8'h14
`define DCTS_A_STAT        8'h18
`define DCTS_A_CH0         8'h20
`define DCTS_A_CH1         8'h40
`define DCTS_O_TAG_TIME    5'h00
`define DCTS_O_TAG_CNT     5'h04
`define DCTS_O_DTIME       5'h08
`define DCTS_O_DCNT        5'h0c
`define DCTS_O_AVG_SUM     5'h10
`define DCTS_O_AVG_N       5'h14
`define DCTS_O_EDGES       5'h18
`define DCTS_B_EN          0
`define DCTS_B_FREQ        2
`define DCTS_B_NEG         4
`define DCTS_B_AVG         6
`define DCTS_B_REMOTE      7
`define DCTS_B_RUN         8
`define DCTS_I_TAG         0
`define DCTS_I_RES         2
`define DCTS_I_TOUT        4
`define DCTS_CTRL_RST      32'h00000043
`endif

// file: dcts_pkg.sv
// Types for the dual channel time stamp counter.
package dcts_pkg;
    typedef struct packed {
        logic [31:0] stamp;
        logic [31:0] count;
    } dcts_tag_t;
    typedef enum logic {
        CAP_ARM  = 1'b0,
        CAP_HOLD = 1'b1
    } dcts_cap_st_t;
    typedef enum logic {
        MS_IDLE = 1'b0,
        MS_RUN  = 1'b1
    } dcts_ms_st_t;
endpackage : dcts_pkg

// file: dcts_top.sv
// Two channel time stamp and edge counter with register port.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dcts_params.svh"
// What this block does
// - System time counter runs every cycle in 10 ns units.
// - Each channel counts every qualifying input edge, never stopping.
// - Armed channel latches time and edge count together, starts fine measurement.
// - After storing a tag, clear capture circuit and re-arm the input.
// - Capturing never pauses or resets the free-running counters.
// - Capture path re-arms within 16 us, allowing 625 tags per 10 ms.
// - Frequency mode accumulates up to 625 tags per 10 ms window.
// - Event mode ignores the edge count and does no averaging.
// - Event mode tags need only about 1 kHz, non-deterministic rate.
// - Front and rear channels capture in parallel on one time counter.
// - Edges count only when crossing threshold in configured direction.
// - Positive slope takes rising crossings, negative slope falling ones.
// - Activity pulse per enabled channel whenever its input triggers.
// - Without remote control, frequency measurements run continuously.
// - Frequency result is count difference over time stamp difference.
// - Gate sets least time between start and end capture, 0.01 to 1000 s.
// - Missing closing edge past timeout ends measurement, result flagged undefined.
module dcts_top #(
    parameter int TICK_CYC = `DCTS_TICK_NS / `DCTS_CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire logic        I_CLK,
    input  wire logic        I_RESETN,
    // Comparator outputs, front and rear.
    input  wire logic [1:0]  I_CH_IN,
    // Register port.
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    // Fine interval converter control.
    output logic      [1:0]  O_TAC_START,
    output logic      [1:0]  O_TAC_CLEAR,
    // Indicators and interrupt.
    output logic      [1:0]  O_ACT,
    output logic             O_IRQ
);
    localparam int HOLD_CYC = (`DCTS_HOLDOFF_NS + `DCTS_CLK_PERIOD_NS - 1) / `DCTS_CLK_PERIOD_NS;
    localparam logic [31:0] SYS_STEP = 32'(`DCTS_CLK_PERIOD_NS / `DCTS_SYS_RES_NS);
    localparam logic [9:0]  AVG_MAX  = 10'(`DCTS_AVG_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Time base and 10 ms tick.
    logic [31:0] sys_q, sys_d;
    logic [31:0] tdiv_q, tdiv_d;
    logic        tick;

    always_comb begin
        sys_d  = sys_q + SYS_STEP;
        tick   = (tdiv_q == 32'(TICK_CYC - 1));
        tdiv_d = tick ? 32'h0 : tdiv_q + 32'h1;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sys_q  <= 32'h0;
            tdiv_q <= 32'h0;
        end else begin
            sys_q  <= sys_d;
            tdiv_q <= tdiv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] gate_q, gate_d;
    logic [31:0] tout_q, tout_d;
    logic [5:0]  imask_q, imask_d;
    logic [5:0]  istat_q, istat_d;
    logic [5:0]  iset;

    always_comb begin
        ctrl_d  = ctrl_q;
        gate_d  = gate_q;
        tout_d  = tout_q;
        imask_d = imask_q;
        istat_d = istat_q;
        if (I_WR) begin
            case (I_ADDR)
                `DCTS_A_CTRL:  ctrl_d = I_WDATA;
                `DCTS_A_GATE:  gate_d = I_WDATA;
                `DCTS_A_TOUT:  tout_d = I_WDATA;
                `DCTS_A_IMASK: imask_d = I_WDATA[5:0];
                `DCTS_A_ISTAT: istat_d = istat_q & ~I_WDATA[5:0];
                default: begin
                end
            endcase
        end
        istat_d = istat_d | iset;
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_q  <= `DCTS_CTRL_RST;
            gate_q  <= `DCTS_GATE_RST;
            tout_q  <= `DCTS_TOUT_RST;
            imask_q <= 6'h0;
            istat_q <= 6'h0;
        end else begin
            ctrl_q  <= ctrl_d;
            gate_q  <= gate_d;
            tout_q  <= tout_d;
            imask_q <= imask_d;
            istat_q <= istat_d;
        end
    end

    assign O_IRQ = |(istat_q & imask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Per channel capture and measurement, one copy per input.
    logic      [31:0] edges_q [2];
    dcts_pkg::dcts_tag_t tag_q [2];
    logic      [31:0] dtime_q [2];
    logic      [31:0] dcnt_q [2];
    logic      [31:0] asum_q [2];
    logic      [9:0]  an_q [2];
    logic      [1:0]  undef_q;
    logic      [1:0]  armed;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic                   in_q, in_d;
        logic                   hit, cap, en, freq, run, avg;
        logic [31:0]            edges_d;
        dcts_pkg::dcts_cap_st_t cst_q, cst_d;
        logic [9:0]             hold_q, hold_d;
        dcts_pkg::dcts_tag_t    tag_d, start_q, start_d;
        dcts_pkg::dcts_ms_st_t  mst_q, mst_d;
        logic [31:0]            el_q, el_d;
        logic [31:0]            dtime_d, dcnt_d;
        logic                   undef_d, res, tmo, clr;
        logic [31:0]            asum_d, wsum_q, wsum_d, wfirst_q, wfirst_d;
        logic [9:0]             an_d, wn_q, wn_d;

        always_comb begin
            en   = ctrl_q[`DCTS_B_EN + c];
            freq = ctrl_q[`DCTS_B_FREQ + c];
            avg  = ctrl_q[`DCTS_B_AVG];
            run  = !ctrl_q[`DCTS_B_REMOTE] || ctrl_q[`DCTS_B_RUN];
            in_d = I_CH_IN[c];
            hit  = ctrl_q[`DCTS_B_NEG + c] ? (in_q && !in_d) : (!in_q && in_d);
            edges_d = hit ? edges_q[c] + 32'h1 : edges_q[c];
            cap  = en && hit && (cst_q == dcts_pkg::CAP_ARM);
            cst_d  = cst_q;
            hold_d = hold_q;
            clr    = 1'b0;
            tag_d  = tag_q[c];
            case (cst_q)
                dcts_pkg::CAP_ARM: begin
                    if (cap) begin
                        cst_d       = dcts_pkg::CAP_HOLD;
                        hold_d      = 10'(HOLD_CYC - 1);
                        tag_d.stamp = sys_q;
                        tag_d.count = freq ? edges_d : 32'h0;
                    end
                end
                dcts_pkg::CAP_HOLD: begin
                    if (hold_q == 10'h0) begin
                        cst_d = dcts_pkg::CAP_ARM;
                        clr   = 1'b1;
                    end else begin
                        hold_d = hold_q - 10'h1;
                    end
                end
                default: cst_d = dcts_pkg::CAP_ARM;
            endcase
            mst_d   = mst_q;
            start_d = start_q;
            el_d    = tick ? el_q + 32'h1 : el_q;
            dtime_d = dtime_q[c];
            dcnt_d  = dcnt_q[c];
            undef_d = undef_q[c];
            res     = 1'b0;
            tmo     = 1'b0;
            case (mst_q)
                dcts_pkg::MS_IDLE: begin
                    if (cap && freq && run) begin
                        mst_d   = dcts_pkg::MS_RUN;
                        start_d = tag_d;
                        el_d    = 32'h0;
                    end
                end
                dcts_pkg::MS_RUN: begin
                    if (!freq || !run) begin
                        mst_d = dcts_pkg::MS_IDLE;
                    end else if (cap && el_q >= gate_q) begin
                        dtime_d = tag_d.stamp - start_q.stamp;
                        dcnt_d  = tag_d.count - start_q.count;
                        start_d = tag_d;
                        el_d    = 32'h0;
                        undef_d = 1'b0;
                        res     = 1'b1;
                    end else if (tick && el_q >= gate_q + tout_q) begin
                        mst_d   = dcts_pkg::MS_IDLE;
                        undef_d = 1'b1;
                        tmo     = 1'b1;
                    end
                end
                default: mst_d = dcts_pkg::MS_IDLE;
            endcase
            asum_d   = asum_q[c];
            an_d     = an_q[c];
            wsum_d   = wsum_q;
            wn_d     = wn_q;
            wfirst_d = wfirst_q;
            if (tick) begin
                asum_d = wsum_q;
                an_d   = wn_q;
                wsum_d = 32'h0;
                wn_d   = 10'h0;
            end
            if (cap && freq && avg && (tick || wn_q < AVG_MAX)) begin
                if (tick || wn_q == 10'h0) begin
                    wfirst_d = sys_q;
                    wsum_d   = 32'h0;
                    wn_d     = 10'h1;
                end else begin
                    wsum_d = wsum_q + (sys_q - wfirst_q);
                    wn_d   = wn_q + 10'h1;
                end
            end
        end

        always_ff @(posedge I_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                in_q           <= 1'b0;
                edges_q[c]     <= 32'h0;
                cst_q          <= dcts_pkg::CAP_ARM;
                hold_q         <= 10'h0;
                tag_q[c]       <= '0;
                mst_q          <= dcts_pkg::MS_IDLE;
                start_q        <= '0;
                el_q           <= 32'h0;
                dtime_q[c]     <= 32'h0;
                dcnt_q[c]      <= 32'h0;
                undef_q[c]     <= 1'b0;
                asum_q[c]      <= 32'h0;
                an_q[c]        <= 10'h0;
                wsum_q         <= 32'h0;
                wn_q           <= 10'h0;
                wfirst_q       <= 32'h0;
                O_TAC_START[c] <= 1'b0;
                O_TAC_CLEAR[c] <= 1'b0;
                O_ACT[c]       <= 1'b0;
            end else begin
                in_q           <= in_d;
                edges_q[c]     <= edges_d;
                cst_q          <= cst_d;
                hold_q         <= hold_d;
                tag_q[c]       <= tag_d;
                mst_q          <= mst_d;
                start_q        <= start_d;
                el_q           <= el_d;
                dtime_q[c]     <= dtime_d;
                dcnt_q[c]      <= dcnt_d;
                undef_q[c]     <= undef_d;
                asum_q[c]      <= asum_d;
                an_q[c]        <= an_d;
                wsum_q         <= wsum_d;
                wn_q           <= wn_d;
                wfirst_q       <= wfirst_d;
                O_TAC_START[c] <= cap;
                O_TAC_CLEAR[c] <= clr;
                O_ACT[c]       <= en && hit;
            end
        end

        assign iset[`DCTS_I_TAG + c]  = cap;
        assign iset[`DCTS_I_RES + c]  = res;
        assign iset[`DCTS_I_TOUT + c] = tmo;
        assign armed[c] = (cst_q == dcts_pkg::CAP_ARM);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe.
    logic [31:0] rd_d;
    logic [31:0] rdata_q;
    logic        chs;
    logic        chh;

    always_comb begin
        rd_d = 32'h0;
        chh  = (I_ADDR[7:5] == 3'(`DCTS_A_CH0 >> 5)) || (I_ADDR[7:5] == 3'(`DCTS_A_CH1 >> 5));
        chs  = (I_ADDR[7:5] == 3'(`DCTS_A_CH1 >> 5));
        if (I_RD) begin
            if (chh) begin
                case (I_ADDR[4:0])
                    `DCTS_O_TAG_TIME: rd_d = tag_q[chs].stamp;
                    `DCTS_O_TAG_CNT:  rd_d = tag_q[chs].count;
                    `DCTS_O_DTIME:    rd_d = dtime_q[chs];
                    `DCTS_O_DCNT:     rd_d = dcnt_q[chs];
                    `DCTS_O_AVG_SUM:  rd_d = asum_q[chs];
                    `DCTS_O_AVG_N:    rd_d = {22'h0, an_q[chs]};
                    `DCTS_O_EDGES:    rd_d = edges_q[chs];
                    default:          rd_d = 32'h0;
                endcase
            end else begin
                case (I_ADDR)
                    `DCTS_A_CTRL:  rd_d = ctrl_q;
                    `DCTS_A_GATE:  rd_d = gate_q;
                    `DCTS_A_TOUT:  rd_d = tout_q;
                    `DCTS_A_ISTAT: rd_d = {26'h0, istat_q};
                    `DCTS_A_IMASK: rd_d = {26'h0, imask_q};
                    `DCTS_A_SYS:   rd_d = sys_q;
                    `DCTS_A_STAT:  rd_d = {28'h0, armed, undef_q};
                    default:       rd_d = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rd_d;
        end
    end

    assign O_RDATA = rdata_q;
endmodule : dcts_top
`default_nettype wire

// file: dcts_top_props.sv
// Concurrent checks on the ports of the time stamp counter.
`timescale 1ns/10ps
`default_nettype none
`include "dcts_params.svh"
module dcts_top_props #(
    parameter int TICK_CYC = 50
) (
    // Inputs of the block.
    input wire logic        I_CLK,
    input wire logic        I_RESETN,
    input wire logic [1:0]  I_CH_IN,
    input wire logic [7:0]  I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    // Outputs of the block.
    input wire logic [31:0] O_RDATA,
    input wire logic [1:0]  O_TAC_START,
    input wire logic [1:0]  O_TAC_CLEAR,
    input wire logic [1:0]  O_ACT,
    input wire logic        O_IRQ
);
    localparam int HOLD = `DCTS_HOLDOFF_NS / `DCTS_CLK_PERIOD_NS;
    logic [31:0] ctrl_q;
    logic [1:0]  mask_q;
    logic [11:0] hold_q;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    //////////////////////////////
    // Shadow of the control and mask registers and of the front hold-off.
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_q <= `DCTS_CTRL_RST;
            mask_q <= 2'h0;
            hold_q <= 12'h0;
        end else begin
            ctrl_q <= (I_WR && I_ADDR == `DCTS_A_CTRL) ? I_WDATA : ctrl_q;
            mask_q <= (I_WR && I_ADDR == `DCTS_A_IMASK) ? I_WDATA[1:0] : mask_q;
            hold_q <= O_TAC_START[0] ? 12'h1 : (O_TAC_CLEAR[0] ? 12'h0 : hold_q + {11'h0, hold_q != 12'h0});
        end
    end
    //////////////////////////////
    a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data not zero outside a read");
    a_sys_step: assert property ((I_RD && I_ADDR == `DCTS_A_SYS) ##1
        (I_RD && I_ADDR == `DCTS_A_SYS) |=> O_RDATA == $past(O_RDATA) + 32'h2)
        else $error("system time did not step by one cycle");
    a_start_act: assert property ((O_TAC_START & ~O_ACT) == 2'h0)
        else $error("capture without activity pulse");
    a_act_rise: assert property ($rose(I_CH_IN[0]) && ctrl_q[0] && !ctrl_q[4] |=> O_ACT[0])
        else $error("rising edge not taken");
    a_act_fall: assert property ($fell(I_CH_IN[0]) && ctrl_q[0] && ctrl_q[4] |=> O_ACT[0])
        else $error("falling edge not taken");
    a_act_edge: assert property (O_ACT[0] |-> $past(I_CH_IN[0]) != $past(I_CH_IN[0], 2))
        else $error("activity without input edge");
    a_clear_time: assert property (O_TAC_CLEAR[0] |-> hold_q == 12'(HOLD))
        else $error("re-arm not at end of hold-off");
    a_start_armed: assert property (O_TAC_START[0] |-> hold_q == 12'h0)
        else $error("capture during hold-off");
    a_irq_mask: assert property (I_WR && I_ADDR == `DCTS_A_IMASK && I_WDATA == 32'h0 |=> !O_IRQ)
        else $error("interrupt high with empty mask");
    a_tag_irq: assert property (O_TAC_START[0] && mask_q[0] |-> O_IRQ)
        else $error("unmasked capture without interrupt");
endmodule : dcts_top_props
bind dcts_top dcts_top_props #(.TICK_CYC(TICK_CYC)) dcts_top_props_inst (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
    .I_CH_IN(I_CH_IN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_TAC_START(O_TAC_START), .O_TAC_CLEAR(O_TAC_CLEAR), .O_ACT(O_ACT), .O_IRQ(O_IRQ));
`default_nettype wire

// file: dcts_cmp_model.sv
// Comparator output model: commanded toggles plus a periodic wave on the front input.
`timescale 1ns/10ps
`default_nettype none
module dcts_cmp_model (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Wave control and levels.
    input  wire logic        i_run,
    input  wire logic [15:0] i_half,
    input  wire logic [1:0]  i_tgl,
    output logic      [1:0]  o_lvl
);
    logic [15:0] cnt_q;
    logic        wrap;
    assign wrap = i_run && cnt_q == i_half - 16'h1;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 16'h0;
            o_lvl <= 2'h0;
        end else begin
            cnt_q <= (i_run && !wrap) ? cnt_q + 16'h1 : 16'h0;
            o_lvl <= o_lvl ^ i_tgl ^ {1'b0, wrap};
        end
    end
endmodule : dcts_cmp_model
`default_nettype wire

// file: tb_dcts_top.sv
// Self-checking bench for the dual channel time stamp counter.
`timescale 1ns/10ps
`default_nettype none
`include "dcts_params.svh"
module tb_dcts_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        run = 1'b0;
    logic [1:0]  tgl = 2'h0;
    logic [1:0]  ch_in;
    logic [31:0] rdata;
    logic [1:0]  act;
    logic        irq;
    logic        rd_prev = 1'b0;
    logic [31:0] n_act = 32'h0;
    logic [32:0] exp_q[$];
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          k;
    always #10 clk = ~clk;
    dcts_top #(.TICK_CYC(50)) dcts_top_inst (.I_CLK(clk), .I_RESETN(resetn), .I_CH_IN(ch_in), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_TAC_START(), .O_TAC_CLEAR(),
        .O_ACT(act), .O_IRQ(irq));
    dcts_cmp_model dcts_cmp_model_inst (.i_clk(clk), .i_resetn(resetn), .i_run(run), .i_half(16'h01f4),
        .i_tgl(tgl), .o_lvl(ch_in));
    //////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back({1'b1, e});
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : reg_rd
    task automatic pulse(input logic [1:0] m);
        tgl <= m;
        @(posedge clk);
        tgl <= 2'h0;
        @(posedge clk);
    endtask : pulse
    task automatic report_and_stop;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    //////////////////////////////
    // Read data stand in the cycle after the strobe; compare them with the oldest note.
    always @(posedge clk) rd_prev <= rd;
    // Count the front activity pulses; each one stands for a single cycle.
    always @(posedge clk) begin
        if (act[0]) begin
            n_act <= n_act + 32'h1;
        end
    end
    always @(negedge clk) begin
        if (rd_prev) begin
            if (exp_q[0][32]) check(rdata, exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        void'($urandom(26052));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        reg_rd(`DCTS_A_CTRL, `DCTS_CTRL_RST);
        reg_rd(`DCTS_A_GATE, `DCTS_GATE_RST);
        reg_rd(`DCTS_A_TOUT, `DCTS_TOUT_RST);
        reg_rd(`DCTS_A_ISTAT, 32'h0);
        reg_rd(`DCTS_A_STAT, 32'h0000000c);
        reg_wr(8'hfc, 32'hffffffff);
        reg_rd(8'hfc, 32'h0);
        rd <= 1'b1;
        addr <= `DCTS_A_SYS;
        exp_q.push_back(33'h0);
        exp_q.push_back(33'h0);
        repeat (2) @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        // Both inputs rise together, then front edges arrive inside the hold-off.
        pulse(2'h3);
        repeat (4) @(posedge clk);
        reg_rd(`DCTS_A_ISTAT, 32'h3);
        reg_rd(`DCTS_A_CH0 + `DCTS_O_TAG_CNT, 32'h0);
        reg_rd(`DCTS_A_CH1 + `DCTS_O_EDGES, 32'h1);
        reg_wr(`DCTS_A_IMASK, 32'h1);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        @(posedge clk);
        reg_wr(`DCTS_A_ISTAT, 32'h1);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        @(posedge clk);
        k = 1 + $urandom % 3;
        repeat (k) begin
            pulse(2'h1);
            repeat ($urandom % 8) @(posedge clk);
            pulse(2'h1);
        end
        repeat (4) @(posedge clk);
        reg_rd(`DCTS_A_CH0 + `DCTS_O_EDGES, 32'(k + 1));
        reg_rd(`DCTS_A_ISTAT, 32'h2);
        repeat (800) @(posedge clk);
        reg_rd(`DCTS_A_STAT, 32'h0000000c);
        // Negative slope: only the falling crossing counts and captures.
        reg_wr(`DCTS_A_CTRL, 32'h00000053);
        reg_wr(`DCTS_A_ISTAT, 32'h0000003f);
        pulse(2'h1);
        pulse(2'h1);
        repeat (4) @(posedge clk);
        reg_rd(`DCTS_A_CH0 + `DCTS_O_EDGES, 32'(k + 2));
        reg_rd(`DCTS_A_ISTAT, 32'h1);
        // Continuous frequency measurement on a wave of 1000 cycles.
        repeat (800) @(posedge clk);
        reg_wr(`DCTS_A_CTRL, 32'h00000047);
        reg_wr(`DCTS_A_GATE, 32'h1);
        reg_wr(`DCTS_A_TOUT, 32'h00000028);
        run <= 1'b1;
        repeat (3500) @(posedge clk);
        reg_rd(`DCTS_A_CH0 + `DCTS_O_DTIME, 32'h000007d0);
        reg_rd(`DCTS_A_CH0 + `DCTS_O_DCNT, 32'h1);
        // The wave stops, so the open measurement must time out.
        run <= 1'b0;
        repeat (900) @(posedge clk);
        reg_wr(`DCTS_A_ISTAT, 32'h0000003f);
        repeat (1300) @(posedge clk);
        reg_rd(`DCTS_A_ISTAT, 32'h00000010);
        reg_rd(`DCTS_A_STAT, 32'h0000000d);
        // One rise together, k rises, one fall on negative slope, three wave rises.
        check(n_act, 32'(k + 5));
        reg_wr(`DCTS_A_IMASK, 32'h0);
        repeat (2) @(posedge clk);
        report_and_stop;
    end
endmodule : tb_dcts_top
`default_nettype wire
